// ===== light_sensor_port.sv
/*
  Holds the sensor's two-wire slave port, command pointer and register set.
  Assumes the link wires come from another clock domain and the conversion
  inputs come from integrator logic running on mclk.
*/
`timescale 1ns/1ps
`include "light_sensor_defines.svh"

// Summary of operation
// R1: Both channels integrate together, results then stored.
// R2: Results buffered, never torn during bus reads.
// R3: New integration starts automatically after transfer.
// R4: Slave address chosen by strap pin level.
// R5: Master appends direction bit after address.
// R6: Only seven-bit addressing is used.
// R7: First written byte is command, rest data.
// R8: Command write, repeated start, then read register.
// R9: Plain read uses previously latched register address.
// R10: Byte without top bit writes held address.
// R11: Command holds control action or register address.
// R12: Special command clears pending interrupt, no data.
// R13: Command pointer is zero after reset.
// R14: Master sets top bit on command bytes.
// R15: Sixteen registers sit behind the command register; the code decodes a five-bit address, offsets up to 5'h1e.
// R16: Master selects register before accessing it.
// R17: Works at standard and fast bus timing.
// R18: Bits six and five pick transaction kind.
// R19: Acknowledge own address only, else stay released.
module light_sensor_port
  import light_sensor_pkg::*;
#(
  parameter logic [7:0] PART_REV = 8'h5a, // Arbitrary value
  parameter logic [7:0] VARIANT  = 8'ha5  // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  two_wire_link_if.device  link,
  input  wire logic [1:0]  addr_strap,
  input  wire logic        conv_done,
  input  wire logic [15:0] ch0_count,
  input  wire logic [15:0] ch1_count,
  input  wire logic [15:0] timer_count,
  output logic             integ_start,
  output logic             int_clear,
  output logic [7:0]       control_q,
  output logic [7:0]       gain_setup_q,
  output logic [7:0]       int_setup_q,
  output logic [7:0]       front_end_q
);

  typedef struct packed {
    dev_st_t         st;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic            rw;
    logic            first;
    logic            nack;
    logic            sda_oe;
    logic [7:0]      cmd_ptr;
    logic [7:0][7:0] cfg;
    logic [7:0]      variant;
    logic [15:0]     sh0;
    logic [15:0]     sh1;
    logic [15:0]     shtm;
    logic [15:0]     d0;
    logic [15:0]     d1;
    logic [15:0]     tm;
    logic            pend;
    logic            integ_start;
    logic            int_clear;
    logic [2:0]      scl_s;
    logic [2:0]      sda_s;
    logic [1:0]      strap_a;
    logic [1:0]      strap_b;
  } port_state_t;

  port_state_t q_ff;
  port_state_t nxt_q;

  // Outputs straight from the state register, dev_sda_o tied low
  assign integ_start  = q_ff.integ_start;
  assign int_clear    = q_ff.int_clear;
  assign control_q    = q_ff.cfg[0];
  assign gain_setup_q = q_ff.cfg[1];
  assign int_setup_q  = q_ff.cfg[2];
  assign front_end_q  = q_ff.cfg[7];
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = q_ff.sda_oe;

  // Next-state logic for the whole port
  always_comb begin
    logic [7:0] rdb;
    logic [7:0] byte_in;
    logic [6:0] my_addr;
    logic       sc;
    logic       scp;
    logic       sd;
    logic       sdp;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    rdb     = 8'h00;
    byte_in = q_ff.shreg;
    my_addr = `SADDR_GND;
    nxt_q   = q_ff;
    nxt_q.integ_start = 1'b0;
    nxt_q.int_clear   = 1'b0;

    // Two-stage synchronisers, third stage is the previous sample
    nxt_q.scl_s   = {q_ff.scl_s[1:0], link.scl};
    nxt_q.sda_s   = {q_ff.sda_s[1:0], link.sda};
    nxt_q.strap_a = addr_strap;
    nxt_q.strap_b = q_ff.strap_a;
    sc    = q_ff.scl_s[1];
    scp   = q_ff.scl_s[2];
    sd    = q_ff.sda_s[1];
    sdp   = q_ff.sda_s[2];
    rise  = sc & ~scp;
    fall  = ~sc & scp;
    start = sc & scp & sdp & ~sd;
    stop  = sc & scp & ~sdp & sd;

    // Strap level picks the slave address
    unique case (q_ff.strap_b) // [R4]
      `STRAP_FLOAT: my_addr = `SADDR_FLOAT;
      `STRAP_VDD:   my_addr = `SADDR_VDD;
      default:      my_addr = `SADDR_GND;
    endcase

    // Read mux over the register set
    case (q_ff.cmd_ptr[`CMD_ADDR_HI:0]) // [R15] [R9]
      `REG_PART_REV: rdb = PART_REV;
      `REG_CH0_LO:   rdb = q_ff.d0[7:0];
      `REG_CH0_HI:   rdb = q_ff.d0[15:8];
      `REG_CH1_LO:   rdb = q_ff.d1[7:0];
      `REG_CH1_HI:   rdb = q_ff.d1[15:8];
      `REG_TMR_LO:   rdb = q_ff.tm[7:0];
      `REG_TMR_HI:   rdb = q_ff.tm[15:8];
      `REG_VARIANT:  rdb = q_ff.variant;
      default: begin
        if (q_ff.cmd_ptr[`CMD_ADDR_HI:0] <= `REG_CFG_LAST) begin
          rdb = q_ff.cfg[q_ff.cmd_ptr[2:0]];
        end
      end
    endcase

    // Capture both channels, publish when no transfer is in flight
    if (conv_done) begin
      nxt_q.sh0  = ch0_count; // [R1]
      nxt_q.sh1  = ch1_count;
      nxt_q.shtm = timer_count;
      nxt_q.pend = 1'b1;
      nxt_q.integ_start = 1'b1; // [R3]
    end else if (q_ff.pend && q_ff.st == DEV_IDLE) begin
      nxt_q.d0   = q_ff.sh0; // [R2]
      nxt_q.d1   = q_ff.sh1;
      nxt_q.tm   = q_ff.shtm;
      nxt_q.pend = 1'b0;
    end

    // Bus framing and byte engine
    if (start) begin
      nxt_q.st     = DEV_ADDR;
      nxt_q.bitcnt = 4'h0;
      nxt_q.sda_oe = 1'b0;
    end else if (stop) begin
      nxt_q.st     = DEV_IDLE;
      nxt_q.sda_oe = 1'b0;
    end else if (rise) begin
      unique case (q_ff.st)
        DEV_ADDR, DEV_WR: begin
          nxt_q.shreg  = {q_ff.shreg[6:0], sd};
          nxt_q.bitcnt = q_ff.bitcnt + 4'h1;
        end
        DEV_RD:     nxt_q.bitcnt = q_ff.bitcnt + 4'h1;
        DEV_RD_ACK: nxt_q.nack = sd;
        default:    nxt_q.nack = q_ff.nack;
      endcase
    end else if (fall) begin
      unique case (q_ff.st)
        DEV_ADDR: begin
          if (q_ff.bitcnt == `ADDR_BITS) begin
            if (q_ff.shreg[7:1] == my_addr) begin // [R6] [R19]
              nxt_q.sda_oe = 1'b1;
              nxt_q.rw     = q_ff.shreg[0]; // [R5]
              nxt_q.st     = DEV_ACK_ADDR;
            end else begin
              nxt_q.st = DEV_IDLE;
            end
          end
        end
        DEV_ACK_ADDR: begin
          nxt_q.bitcnt = 4'h0;
          if (q_ff.rw) begin
            nxt_q.shreg  = rdb; // [R8] [R9]
            nxt_q.sda_oe = ~rdb[7];
            nxt_q.st     = DEV_RD;
          end else begin
            nxt_q.sda_oe = 1'b0;
            nxt_q.first  = 1'b1;
            nxt_q.st     = DEV_WR;
          end
        end
        DEV_WR: begin
          if (q_ff.bitcnt == `ADDR_BITS) begin
            nxt_q.sda_oe = 1'b1;
            nxt_q.st     = DEV_ACK_WR;
            nxt_q.first  = 1'b0;
            if (q_ff.first && byte_in[`CMD_SEL_BIT]) begin // [R7] [R14]
              if (byte_in[`CMD_TYPE_HI:`CMD_TYPE_LO] == `TYPE_SPECIAL) begin
                if (byte_in[`CMD_ADDR_HI:0] == `SPECIAL_INT_CLR) begin
                  nxt_q.int_clear = 1'b1; // [R12]
                end
              end else begin
                nxt_q.cmd_ptr = byte_in; // [R11] [R18] [R16]
              end
            end else begin
              // Data byte at the held address
              if (q_ff.cmd_ptr[`CMD_ADDR_HI:0] <= `REG_CFG_LAST) begin
                nxt_q.cfg[q_ff.cmd_ptr[2:0]] = byte_in; // [R10]
              end else if (q_ff.cmd_ptr[`CMD_ADDR_HI:0] == `REG_VARIANT) begin
                nxt_q.variant = byte_in;
              end
              if (q_ff.cmd_ptr[`CMD_TYPE_HI:`CMD_TYPE_LO] == `TYPE_AUTOINC) begin
                nxt_q.cmd_ptr[`CMD_ADDR_HI:0] =
                  q_ff.cmd_ptr[`CMD_ADDR_HI:0] + 5'h01; // [R18]
              end
            end
          end
        end
        DEV_ACK_WR: begin
          nxt_q.sda_oe = 1'b0;
          nxt_q.bitcnt = 4'h0;
          nxt_q.st     = DEV_WR;
        end
        DEV_RD: begin
          if (q_ff.bitcnt == `ADDR_BITS) begin
            nxt_q.sda_oe = 1'b0;
            nxt_q.st     = DEV_RD_ACK;
            if (q_ff.cmd_ptr[`CMD_TYPE_HI:`CMD_TYPE_LO] == `TYPE_AUTOINC) begin
              nxt_q.cmd_ptr[`CMD_ADDR_HI:0] =
                q_ff.cmd_ptr[`CMD_ADDR_HI:0] + 5'h01; // [R18]
            end
          end else begin
            nxt_q.shreg  = {q_ff.shreg[6:0], 1'b0};
            nxt_q.sda_oe = ~q_ff.shreg[6];
          end
        end
        DEV_RD_ACK: begin
          if (q_ff.nack) begin
            nxt_q.st = DEV_IDLE;
          end else begin
            nxt_q.shreg  = rdb;
            nxt_q.sda_oe = ~rdb[7];
            nxt_q.bitcnt = 4'h0;
            nxt_q.st     = DEV_RD;
          end
        end
        default: nxt_q.st = DEV_IDLE;
      endcase
    end
  end

  // State register, clocked every rising mclk edge; link rate is set by the master, fast mode by default [R17]
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_ff         <= '0;
      q_ff.cmd_ptr <= `CMD_PTR_RESET; // [R13]
      q_ff.cfg     <= {8{`CFG_RESET}};
      q_ff.variant <= VARIANT;
      q_ff.scl_s   <= 3'h7;
      q_ff.sda_s   <= 3'h7;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule // light_sensor_port

// ===== light_sensor_defines.svh
/*
  Holds the named offsets, field positions, reset values and timing counts
  shared by the light sensor port and its bus master.
  Assumes inclusion by bare name from the port, master and bench files.
*/
`ifndef LIGHT_SENSOR_DEFINES_SVH
`define LIGHT_SENSOR_DEFINES_SVH

// Register offsets
`define REG_CONTROL      5'h00
`define REG_CFG_LAST     5'h07
`define REG_PART_REV     5'h12
`define REG_CH0_LO       5'h14
`define REG_CH0_HI       5'h15
`define REG_CH1_LO       5'h16
`define REG_CH1_HI       5'h17
`define REG_TMR_LO       5'h18
`define REG_TMR_HI       5'h19
`define REG_VARIANT      5'h1e

// Command byte layout
`define CMD_SEL_BIT      7
`define CMD_TYPE_HI      6
`define CMD_TYPE_LO      5
`define CMD_ADDR_HI      4
`define TYPE_REPEAT      2'h0
`define TYPE_AUTOINC     2'h1
`define TYPE_SPECIAL     2'h3
`define SPECIAL_INT_CLR  5'h01

// Slave addresses per strap level
`define STRAP_GND        2'h0
`define STRAP_FLOAT      2'h1
`define STRAP_VDD        2'h2
`define SADDR_GND        7'h29
`define SADDR_FLOAT      7'h39
`define SADDR_VDD        7'h49

// Reset values and bits per byte
`define CMD_PTR_RESET    8'h00
`define CFG_RESET        8'h00
`define ADDR_BITS        4'h8

// Host bit timing
`define MCLK_NS          10
`define QUARTER_NS       625
`define QUARTER_CYCLES   ((`QUARTER_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// ===== light_sensor_pkg.sv
/*
  Holds the state types of the light sensor port and its bus master.
  Assumes nothing of its surroundings.
*/
package light_sensor_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ADDR, DEV_ACK_ADDR, DEV_WR, DEV_ACK_WR, DEV_RD, DEV_RD_ACK
  } dev_st_t;

  typedef enum logic [1:0] {
    HST_IDLE, HST_START, HST_BIT, HST_STOP
  } host_st_t;

  typedef enum logic [2:0] {
    SEQ_ADDR_WR, SEQ_CMD, SEQ_DATA, SEQ_ADDR_RD, SEQ_RX
  } host_seq_t;
endpackage

// ===== two_wire_link_if.sv
/*
  Holds the open-drain two-wire link joining the sensor port and master.
  Assumes a pull-up on both wires; a low is made by any enabled driver.
*/
`timescale 1ns/1ps
interface two_wire_link_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // Wired-AND resolution with pull-up
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o,
                output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface // two_wire_link_if

// ===== light_sensor_master.sv
/*
  Holds the bus master end: command writes, data writes, combined reads.
  Assumes single requests from same-clock logic while busy is low.
*/
`timescale 1ns/1ps
`include "light_sensor_defines.svh"

module light_sensor_master
  import light_sensor_pkg::*;
#(
  parameter int QUARTER = `QUARTER_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  two_wire_link_if.host   link,
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic       req_has_data,
  input  wire logic [6:0] req_cmd,
  input  wire logic [7:0] req_wdata,
  input  wire logic [6:0] slave_addr,
  output logic            busy,
  output logic            done,
  output logic            nack_seen,
  output logic [7:0]      rdata
);

  typedef struct packed {
    host_st_t   st;
    host_seq_t  seq;
    logic [1:0] qtr;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       scl_oe;
    logic       sda_oe;
    logic       nack;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
    logic       rd;
    logic       has_data;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic [6:0] saddr;
    logic [1:0] sda_s;
  } host_state_t;

  host_state_t q_ff;
  host_state_t nxt_q;

  // Outputs straight from the state register, host_scl_o and host_sda_o tied low
  assign busy      = q_ff.busy;
  assign done      = q_ff.done;
  assign nack_seen = q_ff.nack;
  assign rdata     = q_ff.rdata;
  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = q_ff.scl_oe;
  assign link.host_sda_oe = q_ff.sda_oe;

  // Next-state logic: quarter-bit sequencer
  always_comb begin
    logic       tick;
    logic       sd;
    logic [7:0] txb;
    tick  = (q_ff.div == 16'(QUARTER - 1));
    sd    = q_ff.sda_s[1];
    txb   = 8'h00;
    nxt_q = q_ff;
    nxt_q.done  = 1'b0;
    nxt_q.sda_s = {q_ff.sda_s[0], link.sda};
    nxt_q.div   = tick ? 16'h0000 : q_ff.div + 16'h0001;
    if (tick) begin
      nxt_q.qtr = q_ff.qtr + 2'h1;
    end

    // Byte to send in the coming slot
    unique case (q_ff.seq)
      SEQ_ADDR_WR: txb = {q_ff.saddr, 1'b0}; // [R5] [R6]
      SEQ_CMD:     txb = q_ff.cmd;
      SEQ_DATA:    txb = q_ff.wdata;
      SEQ_ADDR_RD: txb = {q_ff.saddr, 1'b1};
      SEQ_RX:      txb = 8'h00;
    endcase

    unique case (q_ff.st)
      HST_IDLE: begin
        nxt_q.div = 16'h0000;
        nxt_q.qtr = 2'h0;
        if (req) begin
          nxt_q.st       = HST_START;
          nxt_q.seq      = SEQ_ADDR_WR;
          nxt_q.busy     = 1'b1;
          nxt_q.nack     = 1'b0;
          nxt_q.rd       = req_read;
          nxt_q.has_data = req_has_data;
          nxt_q.cmd      = {1'b1, req_cmd}; // [R14] [R16]
          nxt_q.wdata    = req_wdata;
          nxt_q.saddr    = slave_addr;
        end
      end
      HST_START: if (tick) begin
        unique case (q_ff.qtr)
          2'h0: nxt_q.sda_oe = 1'b0;
          2'h1: nxt_q.scl_oe = 1'b0;
          2'h2: nxt_q.sda_oe = 1'b1;
          2'h3: begin
            nxt_q.scl_oe = 1'b1;
            nxt_q.st     = HST_BIT;
            nxt_q.bitn   = 4'h0;
            nxt_q.tx     = txb;
          end
        endcase
      end
      HST_BIT: if (tick) begin
        unique case (q_ff.qtr)
          2'h0: begin
            if (q_ff.bitn == `ADDR_BITS || q_ff.seq == SEQ_RX) begin
              nxt_q.sda_oe = 1'b0;
            end else begin
              nxt_q.sda_oe = ~q_ff.tx[7];
            end
          end
          2'h1: nxt_q.scl_oe = 1'b0;
          2'h2: begin
            if (q_ff.bitn != `ADDR_BITS) begin
              nxt_q.rx = {q_ff.rx[6:0], sd};
            end else if (q_ff.seq != SEQ_RX) begin
              nxt_q.nack = sd;
            end
          end
          2'h3: begin
            nxt_q.scl_oe = 1'b1;
            if (q_ff.bitn != `ADDR_BITS) begin
              nxt_q.tx   = {q_ff.tx[6:0], 1'b0};
              nxt_q.bitn = q_ff.bitn + 4'h1;
            end else if (q_ff.nack || q_ff.seq == SEQ_RX) begin
              nxt_q.st = HST_STOP;
              if (q_ff.seq == SEQ_RX) begin
                nxt_q.rdata = q_ff.rx;
              end
            end else begin
              nxt_q.bitn = 4'h0;
              unique case (q_ff.seq)
                SEQ_ADDR_WR: begin
                  nxt_q.seq = SEQ_CMD; // [R7]
                  nxt_q.tx  = q_ff.cmd;
                end
                SEQ_CMD: begin
                  if (q_ff.rd) begin
                    nxt_q.seq = SEQ_ADDR_RD; // [R8]
                    nxt_q.st  = HST_START;
                  end else if (q_ff.has_data) begin
                    nxt_q.seq = SEQ_DATA;
                    nxt_q.tx  = q_ff.wdata;
                  end else begin
                    nxt_q.st = HST_STOP;
                  end
                end
                SEQ_ADDR_RD: nxt_q.seq = SEQ_RX;
                default:     nxt_q.st  = HST_STOP;
              endcase
            end
          end
        endcase
      end
      HST_STOP: if (tick) begin
        unique case (q_ff.qtr)
          2'h0: nxt_q.sda_oe = 1'b1;
          2'h1: nxt_q.scl_oe = 1'b0;
          2'h2: nxt_q.sda_oe = 1'b0;
          2'h3: begin
            nxt_q.st   = HST_IDLE;
            nxt_q.busy = 1'b0;
            nxt_q.done = 1'b1;
          end
        endcase
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_ff       <= '0;
      q_ff.sda_s <= 2'h3;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule // light_sensor_master

// ===== light_sensor_link_sva.sv
/*
  Checker for the two-wire link between the sensor port and its master.
  Assumes the bench's mclk and rst and the link's resolved wires.
*/
`timescale 1ns/1ps
module light_sensor_link_sva #(
  parameter int QUARTER = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  logic        scl_d_ff;
  logic [15:0] run_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Cycles spent at the current clock-wire level
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_d_ff <= 1'b1;
      run_ff   <= 16'h0000;
    end else begin
      scl_d_ff <= scl;
      if (scl != scl_d_ff)
        run_ff <= 16'h0001;
      else if (run_ff != 16'hffff)
        run_ff <= run_ff + 16'h0001;
    end
  end

  AST_RST_QUIET: assert property ($fell(rst) |->
    !host_scl_oe && !host_sda_oe && !dev_sda_oe)
    else $error("link driven right after reset");
  AST_SCL_HALF_MIN: assert property ((scl != scl_d_ff) |->
    run_ff >= 2 * QUARTER - 1)
    else $error("clock wire level too short");
  AST_DEV_STILL: assert property (scl && $past(scl) |->
    $stable(dev_sda_oe))
    else $error("port moved data while clock high");
  AST_DEV_DRIVE_LOW: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("port drive began while clock high");
  AST_DEV_HOLD: assert property ($rose(dev_sda_oe) |->
    dev_sda_oe [*8])
    else $error("port drive dropped early");
  AST_NO_CLASH: assert property (scl |->
    !(host_sda_oe && dev_sda_oe))
    else $error("both ends drive data with clock high");
  AST_START_LOW: assert property (scl && $fell(sda) |->
    ##[1:40] !scl)
    else $error("no clock low after start");
  AST_STOP_IDLE: assert property (scl && $rose(sda) |->
    (!host_scl_oe && !dev_sda_oe) [*8])
    else $error("link not idle after stop");
endmodule // light_sensor_link_sva

// ===== light_sensor_i2c_register_port_tb.sv
/*
  Bench joining the sensor port and its master across one link.
  Assumes the design package, header and link interface are compiled.
*/
`timescale 1ns/1ps
`include "light_sensor_defines.svh"
module light_sensor_i2c_register_port_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  addr_strap = 2'h0;
  logic        conv_done = 1'b0;
  logic [15:0] ch0_count = 16'h0000;
  logic [15:0] ch1_count = 16'h0000;
  logic [15:0] timer_count = 16'h0000;
  logic        req = 1'b0;
  logic        req_read = 1'b0;
  logic        req_has_data = 1'b0;
  logic [6:0]  req_cmd = 7'h00;
  logic [7:0]  req_wdata = 8'h00;
  logic [6:0]  slave_addr = `SADDR_GND;
  logic        integ_start, int_clear, busy, done, nack_seen;
  logic [7:0]  control_q, gain_setup_q, int_setup_q, front_end_q, rdata;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          clr_count = 0;

  two_wire_link_if lnk ();

  light_sensor_port i_light_sensor_port (
    .mclk(mclk), .rst(rst), .link(lnk), .addr_strap(addr_strap),
    .conv_done(conv_done), .ch0_count(ch0_count), .ch1_count(ch1_count),
    .timer_count(timer_count), .integ_start(integ_start),
    .int_clear(int_clear), .control_q(control_q),
    .gain_setup_q(gain_setup_q), .int_setup_q(int_setup_q),
    .front_end_q(front_end_q));

  light_sensor_master #(.QUARTER(8)) i_light_sensor_master (
    .mclk(mclk), .rst(rst), .link(lnk), .req(req), .req_read(req_read),
    .req_has_data(req_has_data), .req_cmd(req_cmd),
    .req_wdata(req_wdata), .slave_addr(slave_addr), .busy(busy),
    .done(done), .nack_seen(nack_seen), .rdata(rdata));

  light_sensor_link_sva #(.QUARTER(8)) i_light_sensor_link_sva (
    .mclk(mclk), .rst(rst), .scl(lnk.scl), .sda(lnk.sda),
    .host_scl_oe(lnk.host_scl_oe), .host_sda_oe(lnk.host_sda_oe),
    .dev_sda_oe(lnk.dev_sda_oe));

  // Clock
  always #5 mclk = ~mclk;

  // Cycle ceiling and interrupt-clear pulse count
  always @(posedge mclk) begin
    cycles++;
    if (int_clear === 1'b1)
      clr_count++;
    if (cycles == 70000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Launch one request
  task automatic go(input logic rd, input logic hd, input logic [6:0] cmd,
                    input logic [7:0] wd);
    @(posedge mclk);
    req          <= 1'b1;
    req_read     <= rd;
    req_has_data <= hd;
    req_cmd      <= cmd;
    req_wdata    <= wd;
    @(posedge mclk);
    req <= 1'b0;
  endtask

  // Busy while the frame runs, done under a bound, then a quiet bus
  task automatic fin();
    int n;
    @(posedge mclk);
    check("busy", {7'h00, busy}, 8'h01);
    for (n = 0; n < 2000 && done !== 1'b1; n++)
      @(posedge mclk);
    check("done", {7'h00, done}, 8'h01);
    check("busy_end", {7'h00, busy}, 8'h00);
    repeat (4) @(posedge mclk);
  endtask

  task automatic xfer(input logic rd, input logic hd,
                      input logic [6:0] cmd, input logic [7:0] wd);
    go(rd, hd, cmd, wd);
    fin();
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] adr,
                        input logic [7:0] exp);
    xfer(1'b1, 1'b0, {2'h0, adr}, 8'h00);
    check(nm, rdata, exp);
  endtask

  task automatic pulse_conv();
    @(posedge mclk);
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    @(posedge mclk);
    check("integ_start", {7'h00, integ_start}, 8'h01);
  endtask

  task automatic t_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("control_q", control_q, `CFG_RESET);
    check("gain_setup_q", gain_setup_q, `CFG_RESET);
    check("int_setup_q", int_setup_q, `CFG_RESET);
    check("front_end_q", front_end_q, `CFG_RESET);
    rd_chk("variant", `REG_VARIANT, 8'ha5);
  endtask

  task automatic t_config();
    for (int a = 0; a < 8; a++) begin
      xfer(1'b0, 1'b1, {2'h0, a[4:0]}, 8'hc0 | a[7:0]);
      rd_chk("cfg_rd", a[4:0], 8'hc0 | a[7:0]);
    end
    check("control_q", control_q, 8'hc0);
    check("gain_setup_q", gain_setup_q, 8'hc1);
    check("int_setup_q", int_setup_q, 8'hc2);
    check("front_end_q", front_end_q, 8'hc7);
  endtask

  // Read-only, writable id and unmapped places
  task automatic t_ids();
    rd_chk("part_rev", `REG_PART_REV, 8'h5a);
    xfer(1'b0, 1'b1, {2'h0, `REG_PART_REV}, 8'h00);
    rd_chk("part_rev_ro", `REG_PART_REV, 8'h5a);
    xfer(1'b0, 1'b1, {2'h0, `REG_VARIANT}, 8'h3c);
    rd_chk("variant_wr", `REG_VARIANT, 8'h3c);
    rd_chk("unmapped", 5'h08, 8'h00);
    xfer(1'b0, 1'b1, {2'h0, `REG_CH0_LO}, 8'hff);
    rd_chk("data_ro", `REG_CH0_LO, 8'h00);
  endtask

  task automatic t_conv();
    logic [47:0] v;
    v = 48'h9abc_5678_1234;
    {timer_count, ch1_count, ch0_count} <= v;
    pulse_conv();
    for (int i = 0; i < 6; i++)
      rd_chk("result", `REG_CH0_LO + i[4:0], v[8*i +: 8]);
    go(1'b1, 1'b0, {2'h0, `REG_CH0_LO}, 8'h00);
    repeat (150) @(posedge mclk);
    ch0_count <= 16'h4321;
    pulse_conv();
    fin();
    check("result_held", rdata, 8'h34);
    rd_chk("result_new", `REG_CH0_LO, 8'h21);
  endtask

  // All four transaction kinds aimed at one register
  task automatic t_types();
    int c0;
    c0 = clr_count;
    for (int t = 0; t < 4; t++)
      xfer(1'b0, t != 3, {t[1:0], 5'h02}, 8'h50 + t[7:0]);
    check("int_setup_q", int_setup_q, 8'h52);
    check("no_clear", clr_count[7:0], c0[7:0]);
    xfer(1'b0, 1'b0, {2'h3, `SPECIAL_INT_CLR}, 8'h00);
    check("clear", clr_count[7:0], c0[7:0] + 8'h01);
    check("int_setup_kept", int_setup_q, 8'h52);
  endtask

  task automatic t_strap();
    logic [6:0] tbl [4];
    tbl = '{`SADDR_GND, `SADDR_FLOAT, `SADDR_VDD, `SADDR_GND};
    for (int s = 0; s < 4; s++) begin
      addr_strap <= s[1:0];
      slave_addr <= tbl[s];
      repeat (4) @(posedge mclk);
      xfer(1'b0, 1'b1, 7'h00, 8'h20 + s[7:0]);
      check("ack_own", {7'h00, nack_seen}, 8'h00);
      check("control_q", control_q, 8'h20 + s[7:0]);
      slave_addr <= tbl[s] ^ 7'h01;
      xfer(1'b0, 1'b1, 7'h00, 8'hff);
      check("nack_other", {7'h00, nack_seen}, 8'h01);
      check("control_kept", control_q, 8'h20 + s[7:0]);
    end
    slave_addr <= `SADDR_GND;
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_config();
    t_ids();
    t_conv();
    t_types();
    t_strap();
    t_reset();
    conclude();
  end
endmodule // light_sensor_i2c_register_port_tb
